// file: core/cit_alu.sv
// cit_alu: single-cycle byte ALU with carry, auxiliary carry and overflow.
// assumes the caller only commits flags for accumulator destinations.
`timescale 1ns/1ps
module cit_alu
  import cit_pkg::*;
(
  input  cit_pkg::cit_alu_op_t op,
  input  logic [7:0]           opa,
  input  logic [7:0]           opb,
  input  logic                 cy_in,
  input  logic                 ac_in,
  input  logic                 ov_in,
  output logic [7:0]           res,
  output logic                 cy_out,
  output logic                 ac_out,
  output logic                 ov_out
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic       cin;

  always_comb begin
    res    = opa;
    cy_out = cy_in;
    ac_out = ac_in;
    ov_out = ov_in;
    cin    = (op == CIT_ADD_CY || op == CIT_SUB_CY) ? cy_in : 1'b0;
    sum    = 9'h000;
    nib    = 5'h00;
    unique case (op)
      CIT_ADD, CIT_ADD_CY: begin
        sum    = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
        nib    = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        res    = sum[7:0];
        cy_out = sum[8];
        ac_out = nib[4];
        ov_out = (opa[7] == opb[7]) && (sum[7] != opa[7]);
      end
      CIT_SUB_CY: begin
        sum    = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
        nib    = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
        res    = sum[7:0];
        cy_out = sum[8];
        ac_out = nib[4];
        ov_out = (opa[7] != opb[7]) && (sum[7] != opa[7]);
      end
      CIT_INC: res = opa + 8'h01;
      CIT_DEC: res = opa - 8'h01;
      CIT_AND: res = opa & opb;
      CIT_OR:  res = opa | opb;
      CIT_XOR: res = opa ^ opb;
      CIT_DEC_ADJ: begin
        // carry is only ever set here, never cleared
        sum = {1'b0, opa};
        if (opa[3:0] > BCD_MAX || ac_in) begin
          sum = sum + BCD_FIX_LO;
        end
        if (sum[7:4] > BCD_MAX || cy_in || sum[8]) begin
          sum = {sum[8], sum[7:0]} + BCD_FIX_HI;
        end
        res    = sum[7:0];
        cy_out = cy_in | sum[8];
      end
      CIT_PASS: res = opb;
    endcase
  end

endmodule // cit_alu

// file: core/cit_core.sv
// cit_core: execute stage for the arithmetic and logical instruction groups of an 8-bit core.
// assumes a fetch unit presents whole instructions (opcode plus up to two operand bytes) with valid/ready.
`timescale 1ns/1ps
module cit_core
  import cit_pkg::*;
(
  input  logic             sys_clk,
  input  logic             resetn,
  input  logic             instr_valid,
  input  logic [7:0]       instr_opcode,
  input  logic [7:0]       instr_operand1,
  input  logic [7:0]       instr_operand2,
  output logic             instr_ready,
  output logic             instr_done,
  output logic [cit_pkg::LEN_W-1:0] instr_len,
  output logic             instr_illegal,
  output logic [7:0]       acc_out,
  output logic [7:0]       second_accumulator,
  output logic [7:0]       psw_out,
  output logic [15:0]      data_pointer
);
  import cit_pkg::*;

  logic [7:0]       iram [IRAM_DEPTH];
  logic [7:0]       acc_r, acc_nxt;
  logic [7:0]       sec_r, sec_nxt;
  logic [7:0]       psw_r, psw_nxt;
  logic [15:0]      dp_r, dp_nxt;
  logic             ready_r, done_r, illegal_r;
  logic [LEN_W-1:0] len_r;
  logic [CYC_W-1:0] cnt_r;

  logic [3:0]       grp, lo;
  logic [7:0]       bank_addr, ptr_addr, dir_rd, form_val, form_addr;
  logic             form_ram, form_ok;
  logic [LEN_W-1:0] form_len, len_d;
  logic [CYC_W-1:0] form_cyc, cyc_d;
  cit_alu_op_t      op;
  cit_dst_t         dst;
  logic [7:0]       opa, opb, res, dst_addr;
  logic             illegal, md_go, md_div, inc_dp;
  logic             accept, commit, dir_sfr, ram_we;
  logic             alu_cy, alu_ac, alu_ov;
  logic             md_last, md_ovf;
  logic [7:0]       md_a, md_b;

  assign grp       = instr_opcode[7:4];
  assign lo        = instr_opcode[3:0];
  assign accept    = instr_valid & ready_r;
  assign bank_addr = {3'b000, psw_r[PSW_RS_HI:PSW_RS_LO], lo[2:0]};
  assign ptr_addr  = iram[{3'b000, psw_r[PSW_RS_HI:PSW_RS_LO], 2'b00, lo[0]}];

  ////////////////////////////////////////////////////////////////////////////
  // direct-space read: low half is data memory, upper half the special registers
  always_comb begin
    if (!instr_operand1[SFR_SPACE_BIT]) begin
      dir_rd = iram[instr_operand1];
    end else begin
      unique case (instr_operand1)
        SFR_ACC: dir_rd = acc_r;
        SFR_SEC: dir_rd = sec_r;
        SFR_PSW: dir_rd = psw_r;
        SFR_DPL: dir_rd = dp_r[7:0];
        SFR_DPH: dir_rd = dp_r[15:8];
        default: dir_rd = 8'h00;
      endcase
    end
  end

  // operand form from the low opcode nibble, shared by the arithmetic, logical and inc/dec groups
  always_comb begin
    form_val  = instr_operand1;
    form_addr = instr_operand1;
    form_ram  = 1'b0;
    form_ok   = 1'b1;
    form_len  = LEN_2;
    form_cyc  = CYC_IMM;
    if (lo[3]) begin
      form_val  = iram[bank_addr];
      form_addr = bank_addr;
      form_ram  = 1'b1;
      form_len  = LEN_1;
      form_cyc  = CYC_REG;
    end else if (lo[3:1] == FRM_IND_TAG) begin
      form_val  = iram[ptr_addr];
      form_addr = ptr_addr;
      form_ram  = 1'b1;
      form_len  = LEN_1;
      form_cyc  = CYC_IND;
    end else if (lo == FRM_DIR) begin
      form_val  = dir_rd;
      form_cyc  = CYC_DIR;
    end else if (lo != FRM_IMM) begin
      form_ok   = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode: operation, destination, operands, length and cycle cost
  always_comb begin
    op       = CIT_PASS;
    dst      = DST_NONE;
    opa      = acc_r;
    opb      = form_val;
    dst_addr = instr_operand1;
    len_d    = form_len;
    cyc_d    = form_cyc;
    illegal  = 1'b0;
    md_go    = 1'b0;
    md_div   = 1'b0;
    inc_dp   = 1'b0;
    unique case (grp)
      GRP_ADD, GRP_ADD_CY, GRP_SUB_CY: begin
        op      = (grp == GRP_ADD) ? CIT_ADD : (grp == GRP_ADD_CY) ? CIT_ADD_CY : CIT_SUB_CY;
        dst     = DST_ACC;
        illegal = !form_ok;
      end
      GRP_AND, GRP_OR, GRP_XOR: begin
        op  = (grp == GRP_AND) ? CIT_AND : (grp == GRP_OR) ? CIT_OR : CIT_XOR;
        dst = DST_ACC;
        if (lo == FRM_DIR_A) begin
          dst   = DST_DIR;
          opa   = dir_rd;
          opb   = acc_r;
          len_d = LEN_2;
          cyc_d = CYC_DIR;
        end else if (lo == FRM_DIR_IMM) begin
          dst   = DST_DIR;
          opa   = dir_rd;
          opb   = instr_operand2;
          len_d = LEN_3;
          cyc_d = CYC_DIR_IMM;
        end else begin
          illegal = !form_ok;
        end
      end
      GRP_INC, GRP_DEC: begin
        op = (grp == GRP_INC) ? CIT_INC : CIT_DEC;
        if (lo == FRM_IMM) begin
          dst   = DST_ACC;
          len_d = LEN_1;
          cyc_d = CYC_REG;
        end else begin
          dst      = form_ram ? DST_RAM : DST_DIR;
          opa      = form_val;
          dst_addr = form_addr;
          illegal  = !form_ok;
        end
      end
      default: begin
        len_d = LEN_1;
        cyc_d = CYC_REG;
        unique case (instr_opcode)
          OPC_INC_PTR: inc_dp = 1'b1;
          OPC_MUL: begin
            md_go = 1'b1;
            cyc_d = CYC_MUL;
          end
          OPC_DIV: begin
            md_go  = 1'b1;
            md_div = 1'b1;
            cyc_d  = CYC_DIV;
          end
          OPC_DEC_ADJ: begin
            op  = CIT_DEC_ADJ;
            dst = DST_ACC;
          end
          default: illegal = 1'b1;
        endcase
      end
    endcase
    // any illegal opcode or operand form retires as a one-cycle no-op
    if (illegal) begin
      dst   = DST_NONE;
      len_d = LEN_1;
      cyc_d = CYC_REG;
    end
  end

  cit_alu u_alu (
    .op     (op),
    .opa    (opa),
    .opb    (opb),
    .cy_in  (psw_r[PSW_CY]),
    .ac_in  (psw_r[PSW_AC]),
    .ov_in  (psw_r[PSW_OV]),
    .res    (res),
    .cy_out (alu_cy),
    .ac_out (alu_ac),
    .ov_out (alu_ov)
  );

  cit_muldiv u_muldiv (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (accept & md_go),
    .is_div  (md_div),
    .opa     (acc_r),
    .opb     (sec_r),
    .last    (md_last),
    .res_a   (md_a),
    .res_b   (md_b),
    .ovf     (md_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // writeback selection
  assign commit  = accept & !illegal & !md_go;
  assign dir_sfr = (dst == DST_DIR) && dst_addr[SFR_SPACE_BIT];
  assign ram_we  = commit && ((dst == DST_RAM) || (dst == DST_DIR && !dst_addr[SFR_SPACE_BIT]));

  always_comb begin
    acc_nxt  = acc_r;
    sec_nxt  = sec_r;
    psw_nxt  = psw_r;
    dp_nxt   = dp_r;
    if (md_last) begin
      acc_nxt         = md_a;
      sec_nxt         = md_b;
      psw_nxt[PSW_CY] = 1'b0;
      psw_nxt[PSW_OV] = md_ovf;
    end else if (commit) begin
      if (dst == DST_ACC || (dir_sfr && dst_addr == SFR_ACC)) begin
        acc_nxt = res;
      end
      if (dir_sfr && dst_addr == SFR_SEC) begin
        sec_nxt = res;
      end
      if (dst == DST_ACC) begin
        psw_nxt[PSW_CY] = alu_cy;
        psw_nxt[PSW_AC] = alu_ac;
        psw_nxt[PSW_OV] = alu_ov;
      end else if (dir_sfr && dst_addr == SFR_PSW) begin
        psw_nxt = res;
      end
      if (inc_dp) begin
        dp_nxt = dp_r + 16'h0001;
      end else if (dir_sfr && dst_addr == SFR_DPL) begin
        dp_nxt[7:0] = res;
      end else if (dir_sfr && dst_addr == SFR_DPH) begin
        dp_nxt[15:8] = res;
      end
    end
    // parity always tracks the accumulator, writes to it are ignored
    psw_nxt[PSW_P] = ^acc_nxt;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_r  <= ACC_RST;
      sec_r  <= SEC_RST;
      psw_r  <= PSW_RST;
      dp_r   <= DP_RST;
    end else begin
      acc_r  <= acc_nxt;
      sec_r  <= sec_nxt;
      psw_r  <= psw_nxt;
      dp_r   <= dp_nxt;
    end
  end

  // data memory keeps its contents across reset
  always_ff @(posedge sys_clk) begin
    if (ram_we) begin
      iram[dst_addr] <= res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // issue timing: ready drops for the extra cycles of multi-cycle instructions
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ready_r   <= 1'b1;
      done_r    <= 1'b0;
      cnt_r     <= '0;
      len_r     <= '0;
      illegal_r <= 1'b0;
    end else if (accept) begin
      len_r     <= len_d;
      illegal_r <= illegal;
      if (cyc_d == CYC_REG) begin
        done_r <= 1'b1;
      end else begin
        done_r  <= 1'b0;
        ready_r <= 1'b0;
        cnt_r   <= cyc_d - CYC_REG;
      end
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CYC_REG;
      if (cnt_r == CYC_REG) begin
        done_r  <= 1'b1;
        ready_r <= 1'b1;
      end
    end else begin
      done_r <= 1'b0;
    end
  end

  assign instr_ready        = ready_r;
  assign instr_done         = done_r;
  assign instr_len          = len_r;
  assign instr_illegal      = illegal_r;
  assign acc_out            = acc_r;
  assign second_accumulator = sec_r;
  assign psw_out            = psw_r;
  assign data_pointer       = dp_r;

endmodule // cit_core

// file: core/cit_muldiv.sv
// cit_muldiv: iterative multiply (two bits per step) and restoring divide (one bit per step).
// assumes start is a single-cycle pulse and no new start arrives while busy.
`timescale 1ns/1ps
module cit_muldiv
  import cit_pkg::*;
(
  input  logic       sys_clk,
  input  logic       resetn,
  input  logic       start,
  input  logic       is_div,
  input  logic [7:0] opa,
  input  logic [7:0] opb,
  output logic       last,
  output logic [7:0] res_a,
  output logic [7:0] res_b,
  output logic       ovf
);

  logic [15:0]      work_r;
  logic [15:0]      work_src;
  logic [15:0]      work_nxt;
  logic [7:0]       dvs_r;
  logic [7:0]       dvs;
  logic             div_r;
  logic             div_s;
  logic             busy_r;
  logic [CYC_W-1:0] cnt_r;
  logic [CYC_W-1:0] cnt_s;

  function automatic logic [15:0] mul_step(input logic [15:0] w, input logic [7:0] d);
    logic [8:0] t;
    t = {1'b0, w[15:8]} + (w[0] ? {1'b0, d} : 9'h000);
    return {t, w[7:1]};
  endfunction

  function automatic logic [15:0] div_step(input logic [15:0] w, input logic [7:0] d);
    logic [8:0] t;
    logic       q;
    t = {w[15:8], w[7]};
    q = (t >= {1'b0, d});
    if (q) begin
      t = t - {1'b0, d};
    end
    return {t[7:0], w[6:0], q};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // first step is taken in the start cycle so the last lands on the final cycle
  always_comb begin
    work_src = start ? {8'h00, opa} : work_r;
    dvs      = start ? opb : dvs_r;
    div_s    = start ? is_div : div_r;
    cnt_s    = start ? (is_div ? CYC_DIV : CYC_MUL) : cnt_r;
    work_nxt = div_s ? div_step(work_src, dvs) : mul_step(mul_step(work_src, dvs), dvs);
    last     = (start | busy_r) && (cnt_s == CYC_REG);
    res_a    = work_nxt[7:0];
    res_b    = work_nxt[15:8];
    // zero divisor leaves the quotient undefined and flags overflow
    ovf      = div_s ? (dvs == 8'h00) : (work_nxt[15:8] != 8'h00);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      work_r <= 16'h0000;
      dvs_r  <= 8'h00;
      div_r  <= 1'b0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else if (start | busy_r) begin
      work_r <= work_nxt;
      dvs_r  <= dvs;
      div_r  <= div_s;
      cnt_r  <= cnt_s - CYC_REG;
      busy_r <= !last;
    end
  end

endmodule // cit_muldiv

// file: core/cit_pkg.sv
// cit_pkg: constants and types shared by the arithmetic/logic execute block.
// assumes 8-bit data, 256-byte internal data memory, special registers above 0x7F.
package cit_pkg;

  // special register addresses in the direct space
  localparam logic [7:0] SFR_ACC       = 8'hE0;
  localparam logic [7:0] SFR_SEC       = 8'hF0;
  localparam logic [7:0] SFR_PSW       = 8'hD0;
  localparam logic [7:0] SFR_DPL       = 8'h82;
  localparam logic [7:0] SFR_DPH       = 8'h83;
  localparam int         SFR_SPACE_BIT = 7;

  // reset values
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [7:0]  SEC_RST  = 8'h00;
  localparam logic [7:0]  PSW_RST  = 8'h00;
  localparam logic [15:0] DP_RST   = 16'h0000;

  // status word field positions
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_P  = 0;

  // opcode groups (upper nibble), operand forms (lower nibble) and single whole opcodes
  localparam logic [3:0] GRP_INC  = 4'h0;
  localparam logic [3:0] GRP_DEC  = 4'h1;
  localparam logic [3:0] GRP_ADD  = 4'h2;
  localparam logic [3:0] GRP_ADD_CY = 4'h3;
  localparam logic [3:0] GRP_OR   = 4'h4;
  localparam logic [3:0] GRP_AND  = 4'h5;
  localparam logic [3:0] GRP_XOR  = 4'h6;
  localparam logic [3:0] GRP_SUB_CY = 4'h9;
  localparam logic [3:0] FRM_DIR_A   = 4'h2;
  localparam logic [3:0] FRM_DIR_IMM = 4'h3;
  localparam logic [3:0] FRM_IMM     = 4'h4;
  localparam logic [3:0] FRM_DIR     = 4'h5;
  localparam logic [2:0] FRM_IND_TAG = 3'h3;
  localparam logic [7:0] OPC_INC_PTR  = 8'hA3;
  localparam logic [7:0] OPC_MUL      = 8'hA4;
  localparam logic [7:0] OPC_DIV      = 8'h84;
  localparam logic [7:0] OPC_DEC_ADJ  = 8'hD4;

  // byte lengths and cycle counts
  localparam int         LEN_W = 2;
  localparam int         CYC_W = 4;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [3:0] CYC_REG     = 4'h1;
  localparam logic [3:0] CYC_IND     = 4'h2;
  localparam logic [3:0] CYC_DIR     = 4'h2;
  localparam logic [3:0] CYC_IMM     = 4'h2;
  localparam logic [3:0] CYC_DIR_IMM = 4'h3;
  localparam logic [3:0] CYC_MUL     = 4'h4;
  localparam logic [3:0] CYC_DIV     = 4'h8;

  // decimal adjust
  localparam logic [3:0] BCD_MAX    = 4'h9;
  localparam logic [8:0] BCD_FIX_LO = 9'h006;
  localparam logic [8:0] BCD_FIX_HI = 9'h060;

  localparam int IRAM_DEPTH = 256;

  typedef enum logic [3:0] {
    CIT_ADD, CIT_ADD_CY, CIT_SUB_CY, CIT_INC, CIT_DEC, CIT_AND, CIT_OR, CIT_XOR, CIT_DEC_ADJ, CIT_PASS
  } cit_alu_op_t;

  typedef enum logic [1:0] {DST_NONE, DST_ACC, DST_DIR, DST_RAM} cit_dst_t;

endpackage

// file: dv/cit_core_bench.sv
// cit_core_bench: self-checking bench for the execute block.
// assumes cit_pkg, cit_core and the bound checker are compiled first.
`timescale 1ns/1ps
module cit_core_bench;
  import cit_pkg::*;
  typedef struct {
    logic [1:0] len;
    int         cyc;
    int         t0;
    bit         chk;
    logic [7:0] acc;
    logic [7:0] sec;
    logic [2:0] fl;
    bit         ill;
  } cit_note_t;
  logic             sys_clk = 1'b0;
  logic             resetn = 1'b0;
  logic             instr_valid = 1'b0;
  logic [7:0]       instr_opcode = 8'h00;
  logic [7:0]       instr_operand1 = 8'h00;
  logic [7:0]       instr_operand2 = 8'h00;
  logic             instr_ready, instr_done, instr_illegal;
  logic [LEN_W-1:0] instr_len;
  logic [7:0]       acc_out, second_accumulator, psw_out;
  logic [15:0]      data_pointer, p;
  logic [7:0]       ea, eb, d;
  logic [2:0]       ef;
  logic [3:0]       grp [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
  logic [7:0]       ops [3] = '{8'h24, 8'h34, 8'h94};
  cit_note_t        notes [$];
  cit_note_t        ex, cur;
  int               cnt = 0, mismatches = 0, checks = 0, seed = 5644;
  int               ln, cy;

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cnt <= cnt + 1;

  cit_core cit_core_i (
    .sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .instr_operand1(instr_operand1), .instr_operand2(instr_operand2), .instr_ready(instr_ready),
    .instr_done(instr_done), .instr_len(instr_len), .instr_illegal(instr_illegal), .acc_out(acc_out),
    .second_accumulator(second_accumulator), .psw_out(psw_out), .data_pointer(data_pointer)
  );
  //////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // valid stays up between calls; every issue drives it high again with the new opcode and operands
  task automatic issue(input logic [7:0] op, o1, o2, input int n_len, n_cyc);
    instr_valid <= 1'b1;
    instr_opcode <= op;
    instr_operand1 <= o1;
    instr_operand2 <= o2;
    do @(posedge sys_clk); while (instr_ready !== 1'b1);
    ex.len = 2'(n_len);
    ex.cyc = n_cyc;
    ex.t0 = cnt;
    notes.push_back(ex);
  endtask

  task automatic drain;
    instr_valid <= 1'b0;
    for (int k = 0; k < 20 && notes.size() != 0; k++) @(posedge sys_clk);
    cmp(16'(notes.size()), 16'h0000);
  endtask

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    cmp({second_accumulator, acc_out}, 16'h0000);
    cmp(data_pointer, 16'h0000);
    ea = 8'h00;
    eb = 8'h00;
    ef = 3'b000;
  endtask

  // flags kept as {carry, aux carry, overflow}
  task automatic arith(input logic [7:0] op, input logic [7:0] v);
    logic [8:0] s;
    logic       c;
    c = (op[7:4] == GRP_ADD) ? 1'b0 : ef[2];
    if (op[7:4] == GRP_SUB_CY) begin
      s = {1'b0, ea} - v - c;
      ef = {s[8], {1'b0, ea[3:0]} < v[3:0] + c, (ea[7] != v[7]) && (s[7] != ea[7])};
    end else begin
      s = ea + v + c;
      ef = {s[8], 5'(ea[3:0]) + v[3:0] + c > 5'h0F, (ea[7] == v[7]) && (s[7] != ea[7])};
    end
    ea = s[7:0];
    ex.acc = ea;
    ex.sec = eb;
    ex.fl = ef;
    issue(op, v, 8'h00, 2, 2);
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (instr_done === 1'b1) begin
      cur = notes.pop_front();
      cmp(16'(cnt - cur.t0), 16'(cur.cyc));
      cmp(16'(instr_len), 16'(cur.len));
      cmp(16'(instr_illegal), 16'(cur.ill));
      if (cur.chk) begin
        cmp({second_accumulator, acc_out}, {cur.sec, cur.acc});
        cmp(16'({psw_out[7:6], psw_out[2], psw_out[0]}), 16'({cur.fl, ^cur.acc}));
      end
    end
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    do_reset();
    ex.chk = 0;
    // data memory is not reset: clear r0 first so indirect reads stay defined
    foreach (grp[i]) begin
      issue(8'h53, 8'h00, 8'h00, 3, 3);
      for (int lo = 2; lo <= 8; lo++) begin
        if (lo == 7 || (lo < 4 && !(grp[i] inside {4'h4, 4'h5, 4'h6})))
          continue;
        ln = (lo == 6 || lo == 8 || (lo == 4 && grp[i] < 2)) ? 1 : (lo == 3 ? 3 : 2);
        cy = (lo == 8 || (lo == 4 && grp[i] < 2)) ? 1 : (lo == 3 ? 3 : 2);
        issue({grp[i], 4'(lo)}, 8'hF0, 8'h5A, ln, cy);
      end
    end
    drain();
    do_reset();
    ex.chk = 1;
    arith(8'h24, 8'h15);
    arith(8'h24, 8'h27);
    ex.acc = 8'h42;
    issue(OPC_DEC_ADJ, 8'h00, 8'h00, 1, 1);
    ea = 8'h42;
    for (int k = 0; k < 12; k++)
      arith(ops[k % 3], 8'($random(seed)));
    d = 8'($random(seed)) | 8'h80;
    eb = d;
    ex.sec = d;
    issue(8'h43, SFR_SEC, d, 3, 3);
    p = ea * eb;
    ea = p[7:0];
    eb = p[15:8];
    ef = {1'b0, ef[1], eb != 8'h00};
    ex.acc = ea;
    ex.sec = eb;
    ex.fl = ef;
    issue(OPC_MUL, 8'h00, 8'h00, 1, 4);
    ex.chk = (eb != 8'h00);
    if (ex.chk) begin
      ex.acc = ea / eb;
      ex.sec = ea % eb;
      ex.fl = {1'b0, ef[1], 1'b0};
    end
    issue(OPC_DIV, 8'h00, 8'h00, 1, 8);
    ex.chk = 0;
    issue(8'h53, SFR_SEC, 8'h00, 3, 3);
    issue(OPC_DIV, 8'h00, 8'h00, 1, 8);
    // opcode outside the implemented groups retires as a flagged no-op
    ex.ill = 1;
    issue(8'hA5, 8'h00, 8'h00, 1, 1);
    ex.ill = 0;
    repeat (3) issue(OPC_INC_PTR, 8'h00, 8'h00, 1, 1);
    drain();
    cmp(data_pointer, 16'h0003);
    give_verdict();
  end
endmodule // cit_core_bench

// file: dv/cit_core_props.sv
// cit_core_props: timing and result checks on the execute block ports.
// assumes binding to cit_core; one clock, async active-low reset.
`timescale 1ns/1ps
module cit_core_props
  import cit_pkg::*;
(
  input logic                     sys_clk,
  input logic                     resetn,
  input logic                     instr_valid,
  input logic [7:0]               instr_opcode,
  input logic [7:0]               instr_operand1,
  input logic [7:0]               instr_operand2,
  input logic                     instr_ready,
  input logic                     instr_done,
  input logic [cit_pkg::LEN_W-1:0] instr_len,
  input logic                     instr_illegal,
  input logic [7:0]               acc_out,
  input logic [7:0]               second_accumulator,
  input logic [7:0]               psw_out,
  input logic [15:0]              data_pointer
);
  logic take;
  assign take = instr_valid && instr_ready;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////
  mul_time_a: assert property (take && instr_opcode == OPC_MUL
    |=> !instr_ready [*3] ##1 (instr_ready && instr_done)) else $error("multiply timing wrong");
  div_time_a: assert property (take && instr_opcode == OPC_DIV
    |=> !instr_ready [*7] ##1 (instr_ready && instr_done)) else $error("divide timing wrong");
  one_cycle_a: assert property (take && instr_opcode inside {8'h04, 8'h14, 8'h28, 8'hA3, 8'hD4}
    |=> instr_done && instr_ready && instr_len == LEN_1) else $error("single-cycle op slow");
  ind_time_a: assert property (take && instr_opcode inside {8'h26, 8'h36, 8'h96, 8'h06, 8'h56}
    |=> !instr_ready ##1 (instr_ready && instr_done)) else $error("indirect timing wrong");
  dir_imm_a: assert property (take && instr_opcode inside {8'h43, 8'h53, 8'h63}
    |=> (instr_len == LEN_3 && !instr_ready) [*2] ##1 instr_done) else $error("direct immediate timing wrong");
  imm_add_a: assert property (take && instr_opcode == 8'h24
    |=> acc_out == $past(acc_out) + $past(instr_operand1) && !instr_ready
        && psw_out[PSW_CY] == ({1'b0, $past(acc_out)} + $past(instr_operand1) > 9'h0FF)
    ##1 instr_done) else $error("add immediate wrong");
  data_pointer_inc_a: assert property (take && instr_opcode == OPC_INC_PTR
    |=> data_pointer == $past(data_pointer) + 16'h0001) else $error("pointer not incremented");
  mul_result_a: assert property (take && instr_opcode == OPC_MUL
    |-> ##4 {second_accumulator, acc_out} == $past(acc_out, 4) * $past(second_accumulator, 4))
    else $error("product wrong");
  div_zero_a: assert property (take && instr_opcode == OPC_DIV && second_accumulator == 8'h00
    |-> ##8 psw_out[PSW_OV]) else $error("divide by zero without overflow");
  reset_val_a: assert property ($rose(resetn)
    |-> acc_out == ACC_RST && second_accumulator == SEC_RST && data_pointer == DP_RST)
    else $error("reset values wrong");
endmodule // cit_core_props

bind cit_core cit_core_props cit_core_props_i (
  .sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
  .instr_operand1(instr_operand1), .instr_operand2(instr_operand2), .instr_ready(instr_ready),
  .instr_done(instr_done), .instr_len(instr_len), .instr_illegal(instr_illegal), .acc_out(acc_out),
  .second_accumulator(second_accumulator), .psw_out(psw_out), .data_pointer(data_pointer)
);
